// ### hw/hgir_pkg.sv
// constants for the host global and interrupt register block
package hgir_pkg;
  localparam int unsigned CHANNELS         = 6;
  localparam logic [7:0]  TX_POWER_ADDR    = 8'h00;
  localparam logic [7:0]  RX_POWER_ADDR    = 8'h08;
  localparam logic [7:0]  GLOBAL_EN_ADDR   = 8'h60;
  localparam logic [7:0]  GLOBAL_ST_ADDR   = 8'h61;
  localparam logic [7:0]  IDENTITY_ADDR    = 8'h6e;
  localparam logic [7:0]  VERSION_ADDR     = 8'h6f;
  localparam logic [3:0]  SRC_EN_LOW       = 4'h1;
  localparam logic [3:0]  SRC_ST_LOW       = 4'h2;
  localparam logic [2:0]  LAST_CHANNEL     = 3'h5;
  // arbitrary values, not tied to any part
  localparam logic [7:0]  IDENTITY_VALUE   = 8'ha5;
  localparam logic [7:0]  VERSION_VALUE    = 8'h03;
  localparam logic [5:0]  FIELD_RESET      = 6'h00;
  // source bit positions
  localparam int unsigned DRV_MON_BIT      = 0;
  localparam int unsigned SIG_LOSS_BIT     = 1;
  localparam int unsigned LOCK_LOSS_BIT    = 2;
  localparam int unsigned FIFO_LIM_BIT     = 3;
  localparam int unsigned PAT_ERR_BIT      = 4;
  localparam int unsigned PAT_FULL_BIT     = 5;
  localparam int unsigned DRV_IDLE_CYCLES  = 128;
  localparam logic [7:0]  DRV_IDLE_LAST    = 8'(DRV_IDLE_CYCLES - 1);
  // access latency bound: two bus-clock periods plus this margin
  localparam int unsigned ACCESS_MARGIN_NS = 5;
  localparam int unsigned ACCESS_PERIODS   = 2;
endpackage

// ### hw/hgir_regs.sv
// global and channel interrupt registers behind the parallel host bus
// Behaviour
// (R1) synchronous mode: ready within two bus-clock periods plus 5 ns
// (R2) host holds hardware reset low at least 5 us
// (R3) after hardware reset release all registers hold defaults
// (R4) transmitter on only when its power bit and enable pin are both 1
// (R5) receiver power bits at 0x08 turn each channel receiver on
// (R6) channel interrupt gates at 0x60, read/write, reset to zero
// (R7) channel interrupt flags at 0x61, set on channel interrupt, read clears
// (R8) host reads channel source status to learn interrupt cause
// (R9) fixed identity byte at 0x6e, writes ignored
// (R10) version byte at 0x6f, read only
// (R11) per-channel source gates at 0x01+0x10*n, six sources
// (R12) per-channel source flags at 0x02+0x10*n, read clears
// (R13) active-low interrupt output until flags are read and cleared
// (R14) driver monitor flags after 128 cycles without pulses
// (R15) host supplies bus clock as access timing reference
// (R16) channel flag sets from gated source flag and channel gate
`timescale 1ns/1ns
module hgir_regs
(
  // system
  input  wire logic       clock,
  input  wire logic       srst,
  // host bus pins
  input  wire logic       bus_clock,
  input  wire logic       reset_n,
  input  wire logic       cs_n,
  input  wire logic       rd_n,
  input  wire logic       wr_n,
  input  wire logic [7:0] addr,
  input  wire logic [7:0] data_in,
  output logic      [7:0] data_out,
  output logic            data_oe_n,
  output logic            rdy_n,
  output logic            int_n,
  // line side
  input  wire logic [5:0] tx_enable_pin,
  input  wire logic [5:0] driver_pulse,
  input  wire logic [5:0] signal_loss,
  input  wire logic [5:0] lock_loss,
  input  wire logic [5:0] fifo_limit,
  input  wire logic [5:0] pattern_error,
  input  wire logic [5:0] pattern_count_full,
  output logic      [5:0] tx_on,
  output logic      [5:0] rx_on
);

  typedef enum logic [1:0] {IDLE, WAIT_EDGE, DONE} hgir_bus_type;

  // two-flop synchronisers for the host bus, tx enable and driver pulse pins
  logic [26:0] pin_meta_reg;
  logic [26:0] pin_sync_reg;
  logic [5:0]  pin2_meta_reg;
  logic [5:0]  pin2_sync_reg;
  logic        bclk_prev_reg;
  always_ff @(posedge clock)
  begin
    pin_meta_reg  <= {bus_clock, reset_n, cs_n, rd_n, wr_n,
                      addr, data_in, tx_enable_pin};
    pin_sync_reg  <= pin_meta_reg;
    pin2_meta_reg <= driver_pulse;
    pin2_sync_reg <= pin2_meta_reg;
    bclk_prev_reg <= pin_sync_reg[26];
  end

  wire       s_bclk    = pin_sync_reg[26];
  wire       s_reset_n = pin_sync_reg[25];
  wire       s_cs_n    = pin_sync_reg[24];
  wire       s_rd_n    = pin_sync_reg[23];
  wire       s_wr_n    = pin_sync_reg[22];
  wire [7:0] s_addr    = pin_sync_reg[21:14];
  wire [7:0] s_data    = pin_sync_reg[13:6];
  wire [5:0] s_tx_pin  = pin_sync_reg[5:0];
  wire [5:0] s_pulse   = pin2_sync_reg;

  // hardware reset pin resets every register but the pin synchronisers and edge-detect flops while low
  wire rst = srst | ~s_reset_n; // R3
  wire bclk_rise = s_bclk & ~bclk_prev_reg; // R15

  hgir_bus_type state_reg;
  hgir_bus_type state_next;
  logic         is_read_reg;
  logic [7:0]   rdata_reg;
  logic [5:0]   tx_bits_reg;
  logic [5:0]   rx_bits_reg;
  logic [5:0]   chan_gate_reg;
  logic [5:0]   chan_flag_reg;
  logic [5:0]   src_gate_reg [6];
  logic [5:0]   src_flag_reg [6];

  wire strobe   = ~s_cs_n & (~s_rd_n | ~s_wr_n);
  // access happens on the first bus-clock rise after the strobe
  wire do_acc   = (state_reg == WAIT_EDGE) & bclk_rise; // R1
  wire do_write = do_acc & ~is_read_reg;
  wire do_read  = do_acc & is_read_reg;

  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      IDLE:      if (strobe) state_next = WAIT_EDGE;
      WAIT_EDGE: if (bclk_rise) state_next = DONE;
      DONE:      if (s_cs_n) state_next = IDLE;
    endcase
  end

  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      state_reg   <= IDLE;
      is_read_reg <= 1'b0;
    end
    else
    begin
      state_reg <= state_next;
      if (state_reg == IDLE)
        is_read_reg <= ~s_rd_n;
    end
  end

  // address decode
  wire [2:0] a_chan   = s_addr[6:4];
  wire       a_chan_ok = ~s_addr[7] & (a_chan <= hgir_pkg::LAST_CHANNEL);
  wire       a_src_en = a_chan_ok & (s_addr[3:0] == hgir_pkg::SRC_EN_LOW);
  wire       a_src_st = a_chan_ok & (s_addr[3:0] == hgir_pkg::SRC_ST_LOW);
  wire       a_tx     = s_addr == hgir_pkg::TX_POWER_ADDR;
  wire       a_rx     = s_addr == hgir_pkg::RX_POWER_ADDR;
  wire       a_gen    = s_addr == hgir_pkg::GLOBAL_EN_ADDR;
  wire       a_gst    = s_addr == hgir_pkg::GLOBAL_ST_ADDR;
  wire       a_id     = s_addr == hgir_pkg::IDENTITY_ADDR;
  wire       a_ver    = s_addr == hgir_pkg::VERSION_ADDR;

  wire [7:0] rd_mux =
    a_tx     ? {2'b00, tx_bits_reg} :
    a_rx     ? {2'b00, rx_bits_reg} :
    a_gen    ? {2'b00, chan_gate_reg} :
    a_gst    ? {2'b00, chan_flag_reg} :
    a_id     ? hgir_pkg::IDENTITY_VALUE : // R9
    a_ver    ? hgir_pkg::VERSION_VALUE :  // R10
    a_src_en ? {2'b00, src_gate_reg[a_chan]} :
    a_src_st ? {2'b00, src_flag_reg[a_chan]} :
               8'h00;

  always_ff @(posedge clock)
  begin
    if (rst)
      rdata_reg <= 8'h00;
    else if (do_read)
      rdata_reg <= rd_mux;
  end

  // global control registers; identity and version take no write
  always_ff @(posedge clock)
  begin
    if (rst)
    begin
      tx_bits_reg   <= hgir_pkg::FIELD_RESET;
      rx_bits_reg   <= hgir_pkg::FIELD_RESET;
      chan_gate_reg <= hgir_pkg::FIELD_RESET; // R6
    end
    else if (do_write)
    begin
      if (a_tx)
        tx_bits_reg <= s_data[5:0];
      if (a_rx)
        rx_bits_reg <= s_data[5:0]; // R5
      if (a_gen)
        chan_gate_reg <= s_data[5:0]; // R6
    end
  end

  // per-channel source logic
  logic [5:0] chan_hit;
  genvar n;
  generate
    for (n = 0; n < hgir_pkg::CHANNELS; n++)
    begin : g_chan
      logic [7:0] idle_cnt_reg;
      logic       pulse_prev_reg;
      logic       drv_event_reg;
      wire        sel     = a_chan == 3'(n);
      wire        wr_gate = do_write & a_src_en & sel;
      wire        rd_flag = do_read & a_src_st & sel;
      wire [5:0]  events;
      wire        pulse_edge = s_pulse[n] & ~pulse_prev_reg;

      // no pulse edge for 128 cycles raises one monitor event
      always_ff @(posedge clock)
      begin
        if (rst | pulse_edge)
          idle_cnt_reg <= 8'h00;
        else if (idle_cnt_reg != hgir_pkg::DRV_IDLE_LAST + 8'h01)
          idle_cnt_reg <= idle_cnt_reg + 8'h01;
      end
      always_ff @(posedge clock)
      begin
        pulse_prev_reg <= s_pulse[n];
        drv_event_reg  <= ~rst & ~pulse_edge &
                          (idle_cnt_reg == hgir_pkg::DRV_IDLE_LAST); // R14
      end

      assign events[hgir_pkg::DRV_MON_BIT]   = drv_event_reg;
      assign events[hgir_pkg::SIG_LOSS_BIT]  = signal_loss[n];
      assign events[hgir_pkg::LOCK_LOSS_BIT] = lock_loss[n];
      assign events[hgir_pkg::FIFO_LIM_BIT]  = fifo_limit[n];
      assign events[hgir_pkg::PAT_ERR_BIT]   = pattern_error[n];
      assign events[hgir_pkg::PAT_FULL_BIT]  = pattern_count_full[n];

      always_ff @(posedge clock)
      begin
        if (rst)
          src_gate_reg[n] <= hgir_pkg::FIELD_RESET;
        else if (wr_gate)
          src_gate_reg[n] <= s_data[5:0]; // R11
      end

      // a new event wins over the read clear in the same cycle
      wire [5:0] set_bits = events & src_gate_reg[n];
      always_ff @(posedge clock)
      begin
        if (rst)
          src_flag_reg[n] <= hgir_pkg::FIELD_RESET;
        else
          src_flag_reg[n] <= (rd_flag ? 6'h00 : src_flag_reg[n])
                             | set_bits; // R12
      end

      assign chan_hit[n] = chan_gate_reg[n] &
                           |(src_flag_reg[n] & src_gate_reg[n]); // R16
    end
  endgenerate

  wire clr_gst = do_read & a_gst;
  always_ff @(posedge clock)
  begin
    if (rst)
      chan_flag_reg <= hgir_pkg::FIELD_RESET;
    else
      chan_flag_reg <= (clr_gst ? 6'h00 : chan_flag_reg) | chan_hit; // R7
  end

  // outputs
  logic int_n_reg;
  always_ff @(posedge clock)
  begin
    if (rst)
      int_n_reg <= 1'b1;
    else
      int_n_reg <= ~|chan_flag_reg; // R13
  end

  assign int_n     = int_n_reg;
  assign rdy_n     = ~(state_reg == DONE); // R1
  assign data_out  = rdata_reg;
  assign data_oe_n = ~((state_reg == DONE) & is_read_reg & ~s_cs_n);
  assign tx_on     = tx_bits_reg & s_tx_pin; // R4
  assign rx_on     = rx_bits_reg; // R5

endmodule

// ### dv/hgir_properties.sv
// checker for the host register block
`timescale 1ns/1ns
module hgir_properties
(
  // clock and resets
  input wire logic       clock,
  input wire logic       srst,
  input wire logic       reset_n,
  // bus
  input wire logic       cs_n,
  input wire logic       rd_n,
  input wire logic       wr_n,
  input wire logic       rdy_n,
  input wire logic       data_oe_n,
  input wire logic       int_n,
  // line side
  input wire logic [5:0] tx_enable_pin,
  input wire logic [5:0] tx_on,
  input wire logic [5:0] rx_on
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  // the pin passes two flops, so any of three samples may enable
  tx_gate_a: assert property (
    (tx_on & ~($past(tx_enable_pin) | $past(tx_enable_pin, 2)
    | $past(tx_enable_pin, 3))) == 6'h00) else $error("tx on, pin low");
  reset_dflt_a: assert property (
    !reset_n [*6] |-> rx_on == 6'h00 && rdy_n && int_n)
    else $error("not at defaults");
  ready_cause_a: assert property (
    $fell(rdy_n) |-> !$past(cs_n) && !$past(cs_n, 3))
    else $error("ready without strobe");
  // 2 x 400 ns + 5 ns is just over 16 clocks
  ready_bound_a: assert property (
    $fell(cs_n) && !(rd_n && wr_n) |-> ##[1:16] !rdy_n)
    else $error("ready late");
  ready_hold_a: assert property (!rdy_n && !cs_n |=> !rdy_n)
    else $error("ready dropped early");
  ready_free_a: assert property ($rose(cs_n) |-> ##[1:4] rdy_n)
    else $error("ready stuck");
  drive_win_a: assert property (!data_oe_n |-> !rdy_n)
    else $error("data driven outside access");
  irq_free_a: assert property (
    $rose(int_n) && reset_n |-> !cs_n || !$past(cs_n, 2))
    else $error("interrupt released without read");
  // the chip select reaches the output enable through two flops
  read_drive_a: assert property (
    !rdy_n && !rd_n && !$past(cs_n, 2) |-> !data_oe_n)
    else $error("read data not driven");
  write_quiet_a: assert property (!wr_n |-> data_oe_n)
    else $error("data driven during write");
endmodule
bind hgir_regs hgir_properties chk_u (.*);

// ### dv/hgir_host.sv
// host processor model on the parallel register bus
`timescale 1ns/1ns
module hgir_host
(
  // pacing clock
  input  wire logic       clock,
  // bus pins
  output logic            bus_clock,
  output logic            cs_n,
  output logic            rd_n,
  output logic            wr_n,
  output logic      [7:0] addr,
  output logic      [7:0] data_in,
  input  wire logic [7:0] data_out,
  input  wire logic       rdy_n
);
  initial
  begin
    cs_n = 1'b1;
    rd_n = 1'b1;
    wr_n = 1'b1;
    addr = 8'h5a;
    data_in = 8'h3c;
    bus_clock = 1'b0;
    #7;
    forever #200 bus_clock = ~bus_clock;
  end
  // idle address and data are inverted so stale values never match
  task automatic access(input logic w, input logic [7:0] a, d,
                        output logic [7:0] q);
    @(posedge clock);
    cs_n    <= 1'b0;
    rd_n    <= w;
    wr_n    <= ~w;
    addr    <= a;
    data_in <= w ? d : ~d;
    // a hung access is caught by the bench's cycle ceiling
    do @(posedge clock); while (rdy_n !== 1'b0);
    q = data_out;
    cs_n    <= 1'b1;
    rd_n    <= 1'b1;
    wr_n    <= 1'b1;
    addr    <= ~a;
    data_in <= ~data_in;
    repeat (4) @(posedge clock);
  endtask
endmodule

// ### dv/hgir_regs_bench.sv
// self-checking bench for the host register block
`timescale 1ns/1ns
module hgir_regs_bench;
  typedef struct {logic [7:0] a, d, e;} hgir_row_type;
  logic         clock, srst, reset_n, bus_clock, cs_n, rd_n, wr_n;
  logic         data_oe_n, rdy_n, int_n;
  logic [7:0]   addr, data_in, data_out, q;
  logic [5:0]   tx_pin, pulse, run, tx_on, rx_on;
  logic [5:0]   ev [5];
  int           miscompares, comparisons, cycles;
  hgir_row_type rows [9] = '{
    '{8'h00, 8'hff, 8'h3f},
    '{8'h08, 8'h2a, 8'h2a},
    '{8'h60, 8'h15, 8'h15},
    '{8'h51, 8'h3f, 8'h3f},
    '{8'h01, 8'h02, 8'h02},
    '{8'h6e, 8'h00, hgir_pkg::IDENTITY_VALUE},
    '{8'h6f, 8'h00, hgir_pkg::VERSION_VALUE},
    '{8'h65, 8'hff, 8'h00},
    '{8'h71, 8'hff, 8'h00}};
  hgir_regs dut_u (.clock(clock), .srst(srst), .bus_clock(bus_clock),
    .reset_n(reset_n), .cs_n(cs_n), .rd_n(rd_n), .wr_n(wr_n),
    .addr(addr), .data_in(data_in), .data_out(data_out),
    .data_oe_n(data_oe_n), .rdy_n(rdy_n), .int_n(int_n),
    .tx_enable_pin(tx_pin), .driver_pulse(pulse), .signal_loss(ev[0]),
    .lock_loss(ev[1]), .fifo_limit(ev[2]), .pattern_error(ev[3]),
    .pattern_count_full(ev[4]), .tx_on(tx_on), .rx_on(rx_on));
  hgir_host host_u (.clock(clock), .bus_clock(bus_clock), .cs_n(cs_n),
    .rd_n(rd_n), .wr_n(wr_n), .addr(addr), .data_in(data_in),
    .data_out(data_out), .rdy_n(rdy_n));
  initial
  begin
    clock = 1'b0;
    forever #25 clock = ~clock;
  end
  always @(posedge clock) pulse <= pulse ^ run;
  always @(posedge clock)
  begin
    cycles++;
    if (cycles == 5000)
    begin
      miscompares++;
      finish_test();
    end
  end
  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    comparisons++;
    if (got !== exp)
    begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic wr(logic [7:0] a, d);
    host_u.access(1'b1, a, d, q);
  endtask
  task automatic rd(logic [7:0] a, e);
    host_u.access(1'b0, a, 8'h00, q);
    check("read data", e, q);
  endtask
  task automatic finish_test();
    $display("comparisons %0d miscompares %0d", comparisons, miscompares);
    if (miscompares == 0 && comparisons > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  initial
  begin
    srst = 1'b1;
    reset_n = 1'b1;
    tx_pin = 6'h00;
    pulse = 6'h00;
    run = 6'h3f;
    ev = '{default: 6'h00};
    repeat (6) @(posedge clock);
    srst <= 1'b0;
    repeat (3) @(posedge clock);
    foreach (rows[i])
    begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].e);
    end
    tx_pin <= 6'h05;
    repeat (5) @(posedge clock);
    check("tx_on", 8'h05, {2'b00, tx_on});
    check("rx_on", 8'h2a, {2'b00, rx_on});
    $display("register test done");
    ev[0] <= 6'h01;
    ev[1] <= 6'h02;
    ev[4] <= 6'h20;
    @(posedge clock);
    ev <= '{default: 6'h00};
    repeat (3) @(posedge clock);
    check("int_n", 8'h00, {7'h00, int_n});
    rd(8'h61, 8'h01);
    rd(8'h02, 8'h02);
    rd(8'h61, 8'h01);
    rd(8'h61, 8'h00);
    rd(8'h52, 8'h20);
    rd(8'h12, 8'h00);
    check("int_n", 8'h01, {7'h00, int_n});
    $display("interrupt test done");
    wr(8'h01, 8'h01);
    run <= 6'h3e;
    repeat (100) @(posedge clock);
    check("int_n", 8'h01, {7'h00, int_n});
    repeat (45) @(posedge clock);
    check("int_n", 8'h00, {7'h00, int_n});
    run <= 6'h3f;
    rd(8'h02, 8'h01);
    rd(8'h61, 8'h01);
    rd(8'h61, 8'h00);
    $display("driver monitor test done");
    reset_n <= 1'b0;
    repeat (101) @(posedge clock);
    reset_n <= 1'b1;
    repeat (4) @(posedge clock);
    check("tx_on", 8'h00, {2'b00, tx_on});
    check("rx_on", 8'h00, {2'b00, rx_on});
    rd(8'h60, 8'h00);
    rd(8'h51, 8'h00);
    $display("hardware reset test done");
    finish_test();
  end
endmodule
